// file: rtl/rsm_reset_sequencer.sv
// reset sequence manager: source merge, delay, vector fetch, pin drive
`timescale 1ns/100ps
`include "rsm_cfg.svh"
// Notes on behaviour
// [R1] pin, voltage detector, watchdog all start reset
// [R2] illegal opcode or prebyte also starts reset
// [R3] all sources pull pin; low through delay
// [R4] vector fetched from FFFE then FFFF
// [R5] active, delay, fetch in strict order
// [R6] delay 256 for rc/ext, 4096 crystal
// [R7] vector fetch lasts exactly two cycles
// [R8] multiplier adds start-up delay when enabled
// [R9] pin is input plus open-drain output
// [R10] external pulse caught without clock; min width
// [R11] watchdog underflow drives pin low minimum time
// [R12] voltage detector low drives pin low
// [R13] crystal kept running during reset
// [R14] clock source picked by option setting
// [R15] no multi-oscillator: alternate pin clock
// [R16] outside holds pin low on blank part
// [R17] new source during delay/fetch restarts sequence
module rsm_reset_sequencer #(
	parameter logic [12:0] DELAY_LONG = `RSM_DELAY_LONG,
	parameter logic [12:0] DELAY_SHORT = `RSM_DELAY_SHORT,
	parameter logic [12:0] MUL_STARTUP = `RSM_MUL_STARTUP,
	parameter logic [7:0] WDG_PULSE = `RSM_WDG_PULSE
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic reset_pin_in,
	input wire logic ext_reset_async_in,
	input wire logic low_voltage_detector_in,
	input wire logic watchdog_underflow_in,
	input wire logic illegal_opcode_in,
	input wire logic [1:0] clock_source_in,
	input wire logic multiplier_enable_in,
	input wire logic multi_oscillator_used_in,
	output logic reset_pin_out,
	output logic reset_pin_oe_n_out,
	output logic cpu_reset_out,
	output logic vector_fetch_out,
	output logic [15:0] vector_addr_out,
	output logic clock_gate_out,
	output logic xtal_keep_running_out,
	output logic alt_clock_select_out
);
	rsm_pkg::rsm_state_e state_q;
	logic [3:0] ext_low_q;
	logic ext_latch_q;
	logic ext_req;
	logic [7:0] wdg_cnt_q;
	logic src_any;
	logic hold_src;
	logic [1:0] fetch_cnt_q;
	logic cnt_load;
	logic [12:0] cnt_value;
	logic cnt_zero;
	logic is_xtal;
	logic drive_low_q;
	logic [15:0] vec_q;
	logic fetch_q;
	logic clk_gate_q;
	logic fetch_d;
	logic [12:0] dly_seen_q;

	////////////////////////////////////////////////////////////////
	// source merging
	assign is_xtal = (clock_source_in == `RSM_CLK_XTAL); // R14
	// pin low filter; it restarts while we drive, since our own low is still
	// sampled on the edge that releases the pin and must not read as a request
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ext_low_q <= 4'h0;
		end else if (clk_en_in) begin
			if (reset_pin_in || drive_low_q) begin
				ext_low_q <= 4'h0;
			end else if (ext_low_q != `RSM_EXT_FILTER) begin
				ext_low_q <= ext_low_q + 4'h1; // R10
			end
		end
	end
	// halt wake: the async request is caught even with the enable low
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ext_latch_q <= 1'b0;
		end else if (ext_reset_async_in) begin
			ext_latch_q <= 1'b1; // R10
		end else if (clk_en_in && state_q == rsm_pkg::RSM_ACTIVE) begin
			ext_latch_q <= 1'b0;
		end
	end
	// self-driven low must not count as an outside pulse
	assign ext_req = (ext_low_q == `RSM_EXT_FILTER && !drive_low_q) || ext_latch_q; // R10 R9
	// watchdog pulse stretcher for the least output width
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wdg_cnt_q <= 8'h00;
		end else if (clk_en_in) begin
			if (watchdog_underflow_in) begin
				wdg_cnt_q <= WDG_PULSE; // R11
			end else if (wdg_cnt_q != 8'h00) begin
				wdg_cnt_q <= wdg_cnt_q - 8'h01;
			end
		end
	end
	assign src_any = ext_req || low_voltage_detector_in || watchdog_underflow_in
		|| illegal_opcode_in; // R1 R2
	assign hold_src = src_any || wdg_cnt_q != 8'h00; // R11 R12

	////////////////////////////////////////////////////////////////
	// sequence state
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= rsm_pkg::RSM_ACTIVE;
		end else if (clk_en_in) begin
			if (hold_src) begin
				state_q <= rsm_pkg::RSM_ACTIVE; // R17
			end else begin
				unique case (state_q)
					rsm_pkg::RSM_IDLE: state_q <= rsm_pkg::RSM_IDLE;
					rsm_pkg::RSM_ACTIVE: state_q <= rsm_pkg::RSM_DELAY; // R5
					rsm_pkg::RSM_DELAY: begin
						if (cnt_zero) begin
							state_q <= multiplier_enable_in ? rsm_pkg::RSM_MULT
								: rsm_pkg::RSM_FETCH; // R8 R5
						end
					end
					rsm_pkg::RSM_MULT: begin
						if (cnt_zero) begin
							state_q <= rsm_pkg::RSM_FETCH; // R8
						end
					end
					rsm_pkg::RSM_FETCH: begin
						if (fetch_cnt_q == `RSM_FETCH_CYCLES - 2'h1) begin
							state_q <= rsm_pkg::RSM_IDLE; // R7
						end
					end
				endcase
			end
		end
	end

	// load on entering delay and multiplier phases
	always_comb begin
		cnt_load = 1'b0;
		cnt_value = DELAY_SHORT;
		if (state_q == rsm_pkg::RSM_ACTIVE) begin
			cnt_load = 1'b1;
			cnt_value = (is_xtal ? DELAY_LONG : DELAY_SHORT) - 13'h0002; // R6
		end else if (state_q == rsm_pkg::RSM_DELAY && cnt_zero) begin
			cnt_load = 1'b1;
			cnt_value = MUL_STARTUP - 13'h0001; // R8
		end
	end

	rsm_counter #(
		.WIDTH(13)
	) u_delay (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.enable_in(clk_en_in),
		.load_in(cnt_load),
		.value_in(cnt_value),
		.zero_out(cnt_zero)
	);

	// two-cycle fetch counter, cleared whenever the sequence restarts
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fetch_cnt_q <= 2'h0;
		end else if (clk_en_in) begin
			if (state_q == rsm_pkg::RSM_FETCH && !hold_src) begin
				fetch_cnt_q <= fetch_cnt_q + 2'h1; // R7
			end else begin
				fetch_cnt_q <= 2'h0;
			end
		end
	end

	// cycles spent in the delay phase, watched by the length check below
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dly_seen_q <= 13'h0000;
		end else if (clk_en_in) begin
			if (state_q == rsm_pkg::RSM_DELAY && !hold_src) begin
				dly_seen_q <= dly_seen_q + 13'h0001; // R6
			end else begin
				dly_seen_q <= 13'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	// pin held low from any source through the whole delay phase
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			drive_low_q <= 1'b1;
		end else if (clk_en_in) begin
			drive_low_q <= hold_src || (state_q == rsm_pkg::RSM_ACTIVE)
				|| (state_q == rsm_pkg::RSM_DELAY && !cnt_zero); // R3
		end
	end
	// open-drain: output data always low, enable low means driving
	assign reset_pin_out = 1'b0; // R9
	assign reset_pin_oe_n_out = !drive_low_q; // R9 R3
	assign cpu_reset_out = (state_q != rsm_pkg::RSM_IDLE);

	// fetch is the coming state: flag and address are registered from it,
	// so both stand in the same cycle as the fetch phase itself
	assign fetch_d = !hold_src
		&& ((state_q == rsm_pkg::RSM_DELAY && cnt_zero && !multiplier_enable_in)
		|| (state_q == rsm_pkg::RSM_MULT && cnt_zero)
		|| (state_q == rsm_pkg::RSM_FETCH
		&& fetch_cnt_q != `RSM_FETCH_CYCLES - 2'h1)); // R7
	// vector address low word first, then high word
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			vec_q <= `RSM_VEC_LO;
			fetch_q <= 1'b0;
		end else if (clk_en_in) begin
			fetch_q <= fetch_d; // R7
			vec_q <= (fetch_d && state_q == rsm_pkg::RSM_FETCH) ? `RSM_VEC_HI : `RSM_VEC_LO; // R4
		end
	end
	assign vector_fetch_out = fetch_q;
	assign vector_addr_out = vec_q; // R4

	// multiplied clock withheld until its start-up delay has run
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_gate_q <= 1'b0;
		end else if (clk_en_in) begin
			clk_gate_q <= !(multiplier_enable_in && (state_q == rsm_pkg::RSM_MULT
				|| state_q == rsm_pkg::RSM_DELAY || state_q == rsm_pkg::RSM_ACTIVE)); // R8
		end
	end
	assign clock_gate_out = clk_gate_q;
	assign xtal_keep_running_out = is_xtal; // R13
	assign alt_clock_select_out = !multi_oscillator_used_in; // R15

	////////////////////////////////////////////////////////////////
	// checks
	// fetch phase length and vector order
	a_fetch_two_cycles: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R7
		(clk_en_in && !hold_src && state_q == rsm_pkg::RSM_FETCH && fetch_cnt_q == 2'h0)
		##1 (clk_en_in && !hold_src) |-> state_q == rsm_pkg::RSM_FETCH ##1
		(state_q == rsm_pkg::RSM_IDLE || !clk_en_in || hold_src))
		else $error("vector fetch not two cycles");
	a_vector_order: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R4
		state_q == rsm_pkg::RSM_FETCH && $past(state_q) != rsm_pkg::RSM_FETCH
		|-> vector_addr_out == `RSM_VEC_LO)
		else $error("first vector address wrong");
	a_vector_high: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R4
		state_q == rsm_pkg::RSM_IDLE && $past(state_q) == rsm_pkg::RSM_FETCH
		|-> $past(vector_addr_out) == `RSM_VEC_HI)
		else $error("second vector address wrong");

	// phase order and lengths, and multiplier clock gate
	a_active_to_delay: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R5
		clk_en_in && state_q == rsm_pkg::RSM_ACTIVE && !hold_src
		|=> state_q == rsm_pkg::RSM_DELAY)
		else $error("active phase not followed by delay");
	a_delay_order: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R5
		state_q == rsm_pkg::RSM_FETCH && $past(state_q) != rsm_pkg::RSM_FETCH |->
		$past(state_q) == rsm_pkg::RSM_DELAY || $past(state_q) == rsm_pkg::RSM_MULT)
		else $error("fetch entered out of order");
	a_delay_length: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R6
		clk_en_in && state_q == rsm_pkg::RSM_DELAY && cnt_zero && !hold_src
		|-> dly_seen_q == (is_xtal ? DELAY_LONG : DELAY_SHORT) - 13'h0002)
		else $error("delay phase length wrong");
	a_mult_gate: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R8
		clk_en_in && multiplier_enable_in && state_q == rsm_pkg::RSM_MULT |=>
		!clock_gate_out)
		else $error("clock delivered before start-up");

	// sources and pin
	a_source_restart: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R17 R1 R2
		clk_en_in && src_any |=> state_q == rsm_pkg::RSM_ACTIVE)
		else $error("source did not restart");
	a_async_latch: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R10
		ext_reset_async_in |=> ext_latch_q)
		else $error("async pin request lost");
	a_idle_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R1
		clk_en_in && state_q == rsm_pkg::RSM_IDLE && !hold_src
		|=> state_q == rsm_pkg::RSM_IDLE)
		else $error("reset started with no source");
	a_pin_in_delay: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R3
		clk_en_in && $past(clk_en_in) && state_q == rsm_pkg::RSM_DELAY && !cnt_zero
		&& $past(state_q) == rsm_pkg::RSM_DELAY |-> !reset_pin_oe_n_out)
		else $error("pin released during delay");
	a_lvd_pin_low: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R12
		clk_en_in && low_voltage_detector_in |=> !reset_pin_oe_n_out)
		else $error("pin not low for voltage detector");
	a_wdg_width: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R11
		clk_en_in && watchdog_underflow_in ##1 clk_en_in[*4] |-> !reset_pin_oe_n_out)
		else $error("watchdog pulse too short");
	a_idle_release: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R9
		clk_en_in && state_q == rsm_pkg::RSM_IDLE && !hold_src
		|=> reset_pin_oe_n_out)
		else $error("pin still driven while idle");
	a_pin_drive_low: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R9
		reset_pin_out == 1'b0)
		else $error("open-drain drives high");
endmodule

// file: shared/rsm_cfg.svh
// constants for the reset sequence manager
`ifndef RSM_CFG_SVH
`define RSM_CFG_SVH
`define RSM_DELAY_SHORT 13'h0100
`define RSM_DELAY_LONG 13'h1000
`define RSM_FETCH_CYCLES 2'h2
`define RSM_VEC_LO 16'hFFFE
`define RSM_VEC_HI 16'hFFFF
`define RSM_WDG_PULSE 8'h04
`define RSM_MUL_STARTUP 13'h0100
`define RSM_EXT_FILTER 4'h3
`define RSM_CLK_EXT 2'h0
`define RSM_CLK_XTAL 2'h1
`define RSM_CLK_RC 2'h2
`define RSM_CLK_ALT 2'h3
`endif

// file: shared/rsm_pkg.sv
// types for the reset sequence manager
package rsm_pkg;
	typedef enum logic [2:0] {
		RSM_IDLE,
		RSM_ACTIVE,
		RSM_DELAY,
		RSM_MULT,
		RSM_FETCH
	} rsm_state_e;
endpackage

// file: rtl/rsm_counter.sv
// loadable down counter used for the sequence delays
`timescale 1ns/100ps
module rsm_counter #(
	parameter int WIDTH = 13
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic enable_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] value_in,
	output logic zero_out
);
	logic [WIDTH-1:0] count_q;
	// load wins over counting so a restart always begins a full count
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_q <= '0;
		end else if (enable_in) begin
			if (load_in) begin
				count_q <= value_in;
			end else if (count_q != '0) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
	assign zero_out = (count_q == '0);
endmodule

// file: verif/rsm_pin_model.sv
// outside reset circuitry sharing the open-drain reset pin
`timescale 1ns/100ps
module rsm_pin_model (
	input wire logic dev_oe_n_in,
	input wire logic hold_low_in,
	output logic pin_level_out
);
	// wired-and with weak pull-up, so a released pin reads high
	assign pin_level_out = (dev_oe_n_in && !hold_low_in) ? 1'b1 : 1'b0;
endmodule

// file: verif/tb_top.sv
// self-checking bench for the reset sequencer
`timescale 1ns/100ps
module tb_top;
	// short counts keep the run brief
	localparam int DL = 16;
	localparam int DS = 8;
	localparam int MU = 4;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic async_in = 1'b0, lvd_in = 1'b0, wdg_in = 1'b0, ill_in = 1'b0;
	logic mult_in = 1'b0, mo_in = 1'b1, hold_low = 1'b0;
	logic en = 1'b1;
	logic [1:0] src_sel = 2'h2;
	logic pin_lvl, pin_out, oe_n, cpu_rst, fetch, xtal, alt, gate;
	logic [15:0] addr;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	//////////////////////////////////////////////////////////////
	always #20 clk_in = ~clk_in;
	rsm_pin_model rsm_pin_model_inst (.dev_oe_n_in(oe_n), .hold_low_in(hold_low),
		.pin_level_out(pin_lvl));
	rsm_reset_sequencer #(.DELAY_LONG(13'h0010), .DELAY_SHORT(13'h0008),
		.MUL_STARTUP(13'h0004), .WDG_PULSE(8'h04)) rsm_reset_sequencer_inst (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(en),
		.reset_pin_in(pin_lvl), .ext_reset_async_in(async_in),
		.low_voltage_detector_in(lvd_in), .watchdog_underflow_in(wdg_in),
		.illegal_opcode_in(ill_in), .clock_source_in(src_sel),
		.multiplier_enable_in(mult_in), .multi_oscillator_used_in(mo_in),
		.reset_pin_out(pin_out), .reset_pin_oe_n_out(oe_n), .cpu_reset_out(cpu_rst),
		.vector_fetch_out(fetch), .vector_addr_out(addr), .clock_gate_out(gate),
		.xtal_keep_running_out(xtal), .alt_clock_select_out(alt));
	//////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// hang guard, far above the longest expected run
	always @(posedge clk_in) begin
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	//////////////////////////////////////////////////////////////
	// follows a sequence from source removal to idle
	task automatic finish_seq(input int dly);
		int n;
		n = 0;
		@(negedge clk_in);
		check(oe_n, 1'b0, "pin not pulled");
		check(cpu_rst, 1'b1, "no reset");
		check(gate, !mult_in, "clock before start-up");
		while (fetch !== 1'b1 && n < 9000) begin
			@(negedge clk_in);
			n++;
		end
		check(n >= dly - 3 && n <= dly + 3, 1'b1, "delay length");
		check(addr, 16'hFFFE, "first vector");
		@(negedge clk_in);
		check(addr, 16'hFFFF, "second vector");
		check(fetch, 1'b1, "fetch too short");
		@(negedge clk_in);
		check({fetch, cpu_rst, oe_n, gate}, 4'h3, "not idle");
	endtask
	// k picks the source: pin, detector, watchdog, opcode, async latch
	task automatic src_case(input int k, input logic [1:0] cs, input logic mul);
		@(negedge clk_in);
		src_sel = cs;
		mult_in = mul;
		case (k)
			0: hold_low = 1'b1;
			1: lvd_in = 1'b1;
			2: wdg_in = 1'b1;
			3: ill_in = 1'b1;
			default: async_in = 1'b1;
		endcase
		repeat (k < 2 ? 5 : 1) @(negedge clk_in);
		{hold_low, lvd_in, wdg_in, ill_in, async_in} = 5'h00;
		finish_seq((cs == 2'h1 ? DL : DS) + (mul ? MU : 0));
	endtask
	// second source in mid-delay must restart the full count
	task automatic restart_case();
		@(negedge clk_in);
		src_sel = 2'h1;
		mult_in = 1'b0;
		wdg_in = 1'b1;
		@(negedge clk_in);
		wdg_in = 1'b0;
		repeat (6) @(negedge clk_in);
		ill_in = 1'b1;
		@(negedge clk_in);
		ill_in = 1'b0;
		finish_seq(DL);
	endtask
	// enable low freezes the sequence; it resumes where it stopped
	task automatic freeze_case();
		@(negedge clk_in);
		mult_in = 1'b0;
		src_sel = 2'h2;
		ill_in = 1'b1;
		@(negedge clk_in);
		ill_in = 1'b0;
		en = 1'b0;
		repeat (10) @(negedge clk_in);
		check({cpu_rst, oe_n, fetch}, 3'h4, "enable low not frozen");
		en = 1'b1;
		finish_seq(DS);
	endtask
	// reset in mid-sequence drives the pin and starts over after release
	task automatic reset_case();
		@(negedge clk_in);
		mult_in = 1'b0;
		src_sel = 2'h2;
		ill_in = 1'b1;
		@(negedge clk_in);
		ill_in = 1'b0;
		repeat (3) @(negedge clk_in);
		reset_n_in = 1'b0;
		#1;
		check({cpu_rst, oe_n, gate, fetch}, 4'h8, "reset state");
		repeat (2) @(negedge clk_in);
		reset_n_in = 1'b1;
		finish_seq(DS);
	endtask
	// a one-cycle glitch on the pin is filtered out
	task automatic glitch_case();
		@(negedge clk_in);
		hold_low = 1'b1;
		@(negedge clk_in);
		hold_low = 1'b0;
		repeat (4) @(negedge clk_in);
		check(cpu_rst, 1'b0, "glitch accepted");
		check(pin_out, 1'b0, "pin data not low");
	endtask
	// option decode for crystal keep-alive and alternate clock pin
	task automatic option_case();
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_in);
			src_sel = i[1:0];
			mo_in = i[2];
			#1;
			check(xtal, i[1:0] == 2'h1, "crystal keep-alive");
			check(alt, !i[2], "alternate clock pin");
		end
		mo_in = 1'b1;
	endtask
	//////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(negedge clk_in);
		reset_n_in = 1'b1;
		finish_seq(DS);
		for (int k = 0; k < 5; k++) begin
			src_case(k, 2'h2, 1'b0);
		end
		src_case(1, 2'h1, 1'b0);
		src_case(2, 2'h0, 1'b1);
		src_case(3, 2'h1, 1'b1);
		restart_case();
		freeze_case();
		reset_case();
		glitch_case();
		option_case();
		print_verdict();
	end
endmodule
